// ==== rtl/cmp_params.svh ====
// Offsets, field positions, reset values and timing of the comparator block
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH

`define CMP_ADR_W          12
`define CMP_OFS_START      12'h000
`define CMP_OFS_STOP       12'h004
`define CMP_OFS_SAMPLE     12'h008
`define CMP_OFS_READY      12'h100
`define CMP_OFS_DOWN       12'h104
`define CMP_OFS_UP         12'h108
`define CMP_OFS_CROSS      12'h10C
`define CMP_OFS_LINKS      12'h200
`define CMP_OFS_MASK       12'h300
`define CMP_OFS_MASK_SET   12'h304
`define CMP_OFS_MASK_CLR   12'h308
`define CMP_OFS_RESULT     12'h400
`define CMP_OFS_ON         12'h500
`define CMP_OFS_PIN        12'h504
`define CMP_OFS_REF        12'h508
`define CMP_OFS_EXTREF     12'h50C
`define CMP_OFS_TH         12'h530
`define CMP_OFS_MODE       12'h534
`define CMP_OFS_HYSTERESIS_ON       12'h538
`define CMP_OFS_STATUS     12'h600
`define CMP_OFS_STAT_CLR   12'h604

`define CMP_EV_N           4
`define CMP_EV_READY       0
`define CMP_EV_DOWN        1
`define CMP_EV_UP          2
`define CMP_EV_CROSS       3

`define CMP_LK_W           5
`define CMP_LK_RDY_SAMPLE  0
`define CMP_LK_RDY_STOP    1
`define CMP_LK_DOWN_STOP   2
`define CMP_LK_UP_STOP     3
`define CMP_LK_CROSS_STOP  4

`define CMP_SEL_W          3
`define CMP_REF_IDLE       3'h7
`define CMP_TH_W           6
`define CMP_TH_DN_LSB      0
`define CMP_TH_UP_LSB      8
`define CMP_SP_W           2
`define CMP_MODE_DIFF      8
`define CMP_TRIG_BIT       0

`define CMP_CLK_MHZ        10
`define CMP_SETTLE_NS      10000

`endif

// ==== rtl/cmp_pkg.sv ====
// Types shared by the comparator register block
package cmp_pkg;

    typedef enum logic [1:0]
    {
        CMP_OFF,
        CMP_SETTLE,
        CMP_RUN
    } cmp_state_t;

endpackage : cmp_pkg

// ==== rtl/cmp_regs.sv ====
// Comparator task, event and configuration registers on classic Wishbone
`timescale 1ns/100ps
`include "cmp_params.svh"

// Function
// - Start trigger begins settling of enabled comparator
// - Stop trigger halts comparator, no further crossings
// - Ready flag set once output valid
// - Link bits tie events directly to tasks
// - Mask with set and clear views
// - Reference pick applies only in single-ended
// - Threshold register feeds ladder hysteresis levels in single-ended only
// - Sample trigger captures output into result
// - Up and down flags on directed crossings
// - Cross flag on every output transition while running
// - Hysteresis register ignored in single-ended
module cmp_regs
#(
    parameter int SETTLE_CYC =
        (`CMP_SETTLE_NS * `CMP_CLK_MHZ + 999) / 1000
)
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [`CMP_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    cmp_out_i,
    output logic                         core_on_o,
    output logic      [`CMP_SEL_W-1:0]   pin_pick_o,
    output logic      [`CMP_SEL_W-1:0]   ref_pick_o,
    output logic      [`CMP_SEL_W-1:0]   ext_pick_o,
    output logic      [`CMP_TH_W-1:0]    ladder_o,
    output logic      [`CMP_SP_W-1:0]    speed_o,
    output logic                         diff_o,
    output logic                         hysteresis_on_o,
    output logic                         irq_o
);

    localparam int CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(SETTLE_CYC - 1);

    cmp_pkg::cmp_state_t state_q;
    cmp_pkg::cmp_state_t state_d;
    logic [CW-1:0]              cnt_q;
    logic                       ack_q;
    logic [31:0]                rdat_q;
    logic [`CMP_EV_N-1:0]       flags_q;
    logic [`CMP_EV_N-1:0]       mask_q;
    logic [`CMP_LK_W-1:0]       links_q;
    logic                       result_q;
    logic                       on_q;
    logic [`CMP_SEL_W-1:0]      pin_q;
    logic [`CMP_SEL_W-1:0]      ref_q;
    logic [`CMP_SEL_W-1:0]      ext_q;
    logic [`CMP_TH_W-1:0]       thup_q;
    logic [`CMP_TH_W-1:0]       thdn_q;
    logic [`CMP_SP_W-1:0]       sp_q;
    logic                       diff_q;
    logic                       hysteresis_on_q;

    // Comparator output synchronised before any logic reads it
    wire logic lvl_w;
    wire logic rise_w;
    wire logic fall_w;

    cmp_sync u_sync
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cmp_out_i),
        .lvl_o   (lvl_w),
        .rise_o  (rise_w),
        .fall_o  (fall_w)
    );

    // Bus decode
    wire logic [`CMP_ADR_W-1:0] adr_w = {wb_adr_i[`CMP_ADR_W-1:2], 2'b00};
    wire logic req_w  = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic wr_w   = req_w & wb_we_i;
    wire logic l0_w   = wr_w & wb_sel_i[0];
    wire logic l1_w   = wr_w & wb_sel_i[1];
    wire logic bit0_w = wb_dat_i[`CMP_TRIG_BIT];

    wire logic h_start_w  = adr_w == `CMP_OFS_START;
    wire logic h_stop_w   = adr_w == `CMP_OFS_STOP;
    wire logic h_sample_w = adr_w == `CMP_OFS_SAMPLE;
    wire logic h_ready_w  = adr_w == `CMP_OFS_READY;
    wire logic h_down_w   = adr_w == `CMP_OFS_DOWN;
    wire logic h_up_w     = adr_w == `CMP_OFS_UP;
    wire logic h_cross_w  = adr_w == `CMP_OFS_CROSS;
    wire logic h_links_w  = adr_w == `CMP_OFS_LINKS;
    wire logic h_mask_w   = adr_w == `CMP_OFS_MASK;
    wire logic h_mset_w   = adr_w == `CMP_OFS_MASK_SET;
    wire logic h_mclr_w   = adr_w == `CMP_OFS_MASK_CLR;
    wire logic h_result_w = adr_w == `CMP_OFS_RESULT;
    wire logic h_on_w     = adr_w == `CMP_OFS_ON;
    wire logic h_pin_w    = adr_w == `CMP_OFS_PIN;
    wire logic h_ref_w    = adr_w == `CMP_OFS_REF;
    wire logic h_ext_w    = adr_w == `CMP_OFS_EXTREF;
    wire logic h_th_w     = adr_w == `CMP_OFS_TH;
    wire logic h_mode_w   = adr_w == `CMP_OFS_MODE;
    wire logic h_hysteresis_on_w   = adr_w == `CMP_OFS_HYSTERESIS_ON;
    wire logic h_stat_w   = adr_w == `CMP_OFS_STATUS;
    wire logic h_sclr_w   = adr_w == `CMP_OFS_STAT_CLR;

    // Software tasks
    wire logic sw_start_w  = l0_w & h_start_w & bit0_w;
    wire logic sw_stop_w   = l0_w & h_stop_w & bit0_w;
    wire logic sw_sample_w = l0_w & h_sample_w & bit0_w;

    // Events
    wire logic running_w = state_q == cmp_pkg::CMP_RUN;
    wire logic ev_ready_w = state_q == cmp_pkg::CMP_SETTLE
                            && cnt_q == CNT_LAST;
    wire logic ev_up_w    = running_w & rise_w;
    wire logic ev_down_w  = running_w & fall_w;
    wire logic ev_cross_w = ev_up_w | ev_down_w;
    wire logic [`CMP_EV_N-1:0] ev_w =
        {ev_cross_w, ev_up_w, ev_down_w, ev_ready_w};

    // Event-to-task links
    wire logic lk_stop_w =
        (ev_ready_w & links_q[`CMP_LK_RDY_STOP])
        | (ev_down_w & links_q[`CMP_LK_DOWN_STOP])
        | (ev_up_w & links_q[`CMP_LK_UP_STOP])
        | (ev_cross_w & links_q[`CMP_LK_CROSS_STOP]);
    wire logic lk_sample_w =
        ev_ready_w & links_q[`CMP_LK_RDY_SAMPLE];

    wire logic stop_all_w   = sw_stop_w | lk_stop_w;
    wire logic sample_all_w = sw_sample_w | lk_sample_w;

    // Flag clears: zero written to a flag, or one to the clear view
    wire logic zero0_w = l0_w & ~bit0_w;
    wire logic [`CMP_EV_N-1:0] clr_w =
        {zero0_w & h_cross_w, zero0_w & h_up_w,
         zero0_w & h_down_w, zero0_w & h_ready_w}
        | ({`CMP_EV_N{l0_w & h_sclr_w}} & wb_dat_i[`CMP_EV_N-1:0]);
    wire logic [`CMP_EV_N-1:0] keep_w = flags_q & ~clr_w;
    wire logic [`CMP_EV_N-1:0] flags_d = ev_w | keep_w;

    // Interrupt mask with three views
    wire logic [`CMP_EV_N-1:0] wmask_w = wb_dat_i[`CMP_EV_N-1:0];
    wire logic [`CMP_EV_N-1:0] mask_d =
        (l0_w & h_mask_w) ? wmask_w :
        (l0_w & h_mset_w) ? (mask_q | wmask_w) :
        (l0_w & h_mclr_w) ? (mask_q & ~wmask_w) : mask_q;

    // Read mux
    wire logic [31:0] th_rd_w =
        {18'h0_0000, thup_q, 2'b00, thdn_q};
    wire logic [31:0] mode_rd_w =
        {23'h00_0000, diff_q, 6'h00, sp_q};
    wire logic [31:0] rd_w =
        h_ready_w  ? {31'h0, flags_q[`CMP_EV_READY]} :
        h_down_w   ? {31'h0, flags_q[`CMP_EV_DOWN]} :
        h_up_w     ? {31'h0, flags_q[`CMP_EV_UP]} :
        h_cross_w  ? {31'h0, flags_q[`CMP_EV_CROSS]} :
        h_links_w  ? {27'h0, links_q} :
        (h_mask_w | h_mset_w | h_mclr_w) ? {28'h0, mask_q} :
        h_result_w ? {31'h0, result_q} :
        h_on_w     ? {31'h0, on_q} :
        h_pin_w    ? {29'h0, pin_q} :
        h_ref_w    ? {29'h0, ref_q} :
        h_ext_w    ? {29'h0, ext_q} :
        h_th_w     ? th_rd_w :
        h_mode_w   ? mode_rd_w :
        h_hysteresis_on_w   ? {31'h0, hysteresis_on_q} :
        h_stat_w   ? {28'h0, flags_q} : 32'h0000_0000;

    // Comparator sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            cmp_pkg::CMP_OFF:
            begin
                if (sw_start_w && on_q && !stop_all_w)
                    state_d = cmp_pkg::CMP_SETTLE;
            end
            cmp_pkg::CMP_SETTLE:
            begin
                if (ev_ready_w)
                    state_d = cmp_pkg::CMP_RUN;
            end
            cmp_pkg::CMP_RUN:
            begin
                state_d = cmp_pkg::CMP_RUN;
            end
            default:
            begin
                state_d = cmp_pkg::CMP_OFF;
            end
        endcase
        if (stop_all_w || !on_q)
            state_d = cmp_pkg::CMP_OFF;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= cmp_pkg::CMP_OFF;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= (state_d == cmp_pkg::CMP_SETTLE
                        && state_q == cmp_pkg::CMP_SETTLE)
                       ? cnt_q + 1'b1 : '0;
        end
    end

    // Bus slave: ack one cycle after request, dropped next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end
        else
        begin
            ack_q  <= req_w;
            rdat_q <= req_w ? rd_w : rdat_q;
        end
    end

    // Flags, mask, result
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_q  <= '0;
            mask_q   <= '0;
            result_q <= 1'b0;
        end
        else
        begin
            flags_q  <= flags_d;
            mask_q   <= mask_d;
            result_q <= sample_all_w ? lvl_w : result_q;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            links_q <= '0;
            on_q    <= 1'b0;
            pin_q   <= '0;
            ref_q   <= '0;
            ext_q   <= '0;
            thdn_q  <= '0;
            thup_q  <= '0;
            sp_q    <= '0;
            diff_q  <= 1'b0;
            hysteresis_on_q  <= 1'b0;
        end
        else
        begin
            if (l0_w & h_links_w)
                links_q <= wb_dat_i[`CMP_LK_W-1:0];
            if (l0_w & h_on_w)
                on_q <= bit0_w;
            if (l0_w & h_pin_w)
                pin_q <= wb_dat_i[`CMP_SEL_W-1:0];
            if (l0_w & h_ref_w)
                ref_q <= wb_dat_i[`CMP_SEL_W-1:0];
            if (l0_w & h_ext_w)
                ext_q <= wb_dat_i[`CMP_SEL_W-1:0];
            if (l0_w & h_th_w)
                thdn_q <= wb_dat_i[`CMP_TH_DN_LSB +: `CMP_TH_W];
            if (l1_w & h_th_w)
                thup_q <= wb_dat_i[`CMP_TH_UP_LSB +: `CMP_TH_W];
            if (l0_w & h_mode_w)
                sp_q <= wb_dat_i[`CMP_SP_W-1:0];
            if (l1_w & h_mode_w)
                diff_q <= wb_dat_i[`CMP_MODE_DIFF];
            if (l0_w & h_hysteresis_on_w & diff_q)
                hysteresis_on_q <= bit0_w;
        end
    end

    // Outputs toward the analog core and the system
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_on_o  <= 1'b0;
            pin_pick_o <= '0;
            ref_pick_o <= `CMP_REF_IDLE;
            ext_pick_o <= '0;
            ladder_o   <= '0;
            speed_o    <= '0;
            diff_o     <= 1'b0;
            hysteresis_on_o     <= 1'b0;
            irq_o      <= 1'b0;
        end
        else
        begin
            core_on_o  <= state_q != cmp_pkg::CMP_OFF;
            pin_pick_o <= pin_q;
            ref_pick_o <= diff_q ? `CMP_REF_IDLE : ref_q;
            ext_pick_o <= ext_q;
            ladder_o   <= diff_q ? '0 : (lvl_w ? thdn_q : thup_q);
            speed_o    <= sp_q;
            diff_o     <= diff_q;
            hysteresis_on_o     <= diff_q & hysteresis_on_q;
            irq_o      <= |(flags_q & mask_q);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_start_ok;
        sw_start_w && on_q && !stop_all_w
        && state_q == cmp_pkg::CMP_OFF;
    endsequence

    property p_start;
        s_start_ok |=> state_q == cmp_pkg::CMP_SETTLE && cnt_q == '0;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not enter settling");

    wire logic core_on_w_chk = state_q != cmp_pkg::CMP_OFF;
    property p_stop;
        sw_stop_w |=> !core_on_w_chk ##1 (!ev_up_w && !ev_down_w) [*3];
    endproperty
    a_stop: assert property (p_stop)
        else $error("crossing after stop");

    property p_ready;
        ev_ready_w |=> flags_q[`CMP_EV_READY]
                       && (state_q == cmp_pkg::CMP_RUN
                           || $past(stop_all_w || !on_q));
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready flag not raised");

    property p_run_after_ready;
        $rose(state_q == cmp_pkg::CMP_RUN) |-> $past(ev_ready_w);
    endproperty
    a_run_after_ready: assert property (p_run_after_ready)
        else $error("running without ready event");

    property p_link_stop;
        ev_ready_w && links_q[`CMP_LK_RDY_STOP]
        |=> state_q == cmp_pkg::CMP_OFF ##1 !core_on_o;
    endproperty
    a_link_stop: assert property (p_link_stop)
        else $error("ready-stop link failed");

    property p_mask_set;
        l0_w && h_mset_w && wb_dat_i[0] |=> mask_q[0]
            ##1 irq_o == $past(|(flags_q & mask_q));
    endproperty
    a_mask_set: assert property (p_mask_set)
        else $error("mask set view failed");

    property p_ref;
        !diff_q && !$past(rst_i) |=> ref_pick_o == $past(ref_q);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference pick wrong in single-ended");

    property p_ladder;
        !diff_q |=> ladder_o == ($past(lvl_w) ? $past(thdn_q)
                                              : $past(thup_q));
    endproperty
    a_ladder: assert property (p_ladder)
        else $error("ladder level wrong");

    property p_sample;
        sw_sample_w |=> result_q == $past(lvl_w);
    endproperty
    a_sample: assert property (p_sample)
        else $error("sample not captured");

    property p_up;
        running_w && rise_w |=> flags_q[`CMP_EV_UP]
                                && flags_q[`CMP_EV_CROSS];
    endproperty
    a_up: assert property (p_up)
        else $error("upward crossing lost");

    property p_cross;
        running_w && fall_w |=> flags_q[`CMP_EV_CROSS]
                                && flags_q[`CMP_EV_DOWN];
    endproperty
    a_cross: assert property (p_cross)
        else $error("crossing flag not raised");

    property p_hysteresis_on;
        l0_w && h_hysteresis_on_w && !diff_q |=> $stable(hysteresis_on_q) && !hysteresis_on_o;
    endproperty
    a_hysteresis_on: assert property (p_hysteresis_on)
        else $error("hysteresis written in single-ended");

    property p_sticky;
        1'b1 |=> ((flags_q & $past(keep_w)) == $past(keep_w));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");

    property p_ack;
        req_w |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack timing wrong");

endmodule : cmp_regs

// ==== rtl/cmp_sync.sv ====
// Two-stage synchroniser with edge detection for the comparator output
`timescale 1ns/100ps

module cmp_sync
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output wire logic lvl_o,
    output wire logic rise_o,
    output wire logic fall_o
);

    logic meta_q;
    logic lvl_q;
    logic prev_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= 1'b0;
            lvl_q  <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            lvl_q  <= meta_q;
            prev_q <= lvl_q;
        end
    end

    assign lvl_o  = lvl_q;
    assign rise_o = lvl_q & ~prev_q;
    assign fall_o = ~lvl_q & prev_q;

endmodule : cmp_sync

// ==== tb/tb_cmp_regs.sv ====
// Self-checking bench for the comparator register block
`timescale 1ns/100ps
`include "cmp_params.svh"

module tb_cmp_regs;

    logic                  clk_i;
    logic                  rst_i     = 1'b1;
    logic                  wb_cyc_i  = 1'b0;
    logic                  wb_stb_i  = 1'b0;
    logic                  wb_we_i   = 1'b0;
    logic [`CMP_ADR_W-1:0] wb_adr_i  = '0;
    logic [3:0]            wb_sel_i  = 4'h0;
    logic [31:0]           wb_dat_i  = 32'h0000_0000;
    logic [31:0]           wb_dat_o;
    logic                  wb_ack_o;
    logic                  cmp_out_i = 1'b0;
    logic                  core_on_o;
    logic [`CMP_SEL_W-1:0] pin_pick_o;
    logic [`CMP_SEL_W-1:0] ref_pick_o;
    logic [`CMP_SEL_W-1:0] ext_pick_o;
    logic [`CMP_TH_W-1:0]  ladder_o;
    logic [`CMP_SP_W-1:0]  speed_o;
    logic                  diff_o;
    logic                  hysteresis_on_o;
    logic                  irq_o;
    int                    fails     = 0;
    int                    tests_run = 0;
    int                    seed      = 41;
    logic [31:0]           exp_q[$];
    logic [31:0]           exp_v;
    logic [31:0]           v;
    logic [31:0]           th;
    logic [11:0]           flag_ofs[4] = '{`CMP_OFS_READY, `CMP_OFS_DOWN,
                                           `CMP_OFS_UP, `CMP_OFS_CROSS};

    cmp_regs #(.SETTLE_CYC(4)) i_cmp_regs
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wb_cyc_i   (wb_cyc_i),
        .wb_stb_i   (wb_stb_i),
        .wb_we_i    (wb_we_i),
        .wb_adr_i   (wb_adr_i),
        .wb_sel_i   (wb_sel_i),
        .wb_dat_i   (wb_dat_i),
        .wb_dat_o   (wb_dat_o),
        .wb_ack_o   (wb_ack_o),
        .cmp_out_i  (cmp_out_i),
        .core_on_o  (core_on_o),
        .pin_pick_o (pin_pick_o),
        .ref_pick_o (ref_pick_o),
        .ext_pick_o (ext_pick_o),
        .ladder_o   (ladder_o),
        .speed_o    (speed_o),
        .diff_o     (diff_o),
        .hysteresis_on_o     (hysteresis_on_o),
        .irq_o      (irq_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task final_report;
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle, held until ack is sampled high
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fails++;
            final_report();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : bus

    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    task settle;
        repeat (2) @(negedge clk_i);
    endtask : settle

    task wait_sync;
        repeat (6) @(posedge clk_i);
    endtask : wait_sync

    // Read results compared against the oldest note
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
        begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
            chk(wb_dat_o, exp_v);
        end
    end

    initial
    begin
        #(100 * 6000);
        fails++;
        final_report();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        // Single-ended after reset: pick follows its register
        chk(ref_pick_o, 32'h0000_0000);
        chk(irq_o, 32'h0000_0000);
        chk(core_on_o, 32'h0000_0000);
        foreach (flag_ofs[i]) rd(flag_ofs[i], 32'h0000_0000);
        rd(`CMP_OFS_LINKS, 32'h0000_0000);
        rd(`CMP_OFS_MASK, 32'h0000_0000);
        rd(12'h7f0, 32'h0000_0000);
        wr(`CMP_OFS_START, 32'h0000_0001);
        settle();
        chk(core_on_o, 32'h0000_0000);
        wr(`CMP_OFS_ON, 32'h0000_0001);
        wr(`CMP_OFS_START, 32'h0000_0001);
        settle();
        chk(core_on_o, 32'h0000_0001);
        repeat (8) @(posedge clk_i);
        rd(`CMP_OFS_READY, 32'h0000_0001);
        cmp_out_i <= 1'b1;
        wait_sync();
        rd(`CMP_OFS_UP, 32'h0000_0001);
        rd(`CMP_OFS_CROSS, 32'h0000_0001);
        rd(`CMP_OFS_DOWN, 32'h0000_0000);
        wr(`CMP_OFS_UP, 32'h0000_0001);
        rd(`CMP_OFS_UP, 32'h0000_0001);
        wr(`CMP_OFS_UP, 32'h0000_0000);
        rd(`CMP_OFS_UP, 32'h0000_0000);
        wr(`CMP_OFS_CROSS, 32'h0000_0000);
        cmp_out_i <= 1'b0;
        wait_sync();
        rd(`CMP_OFS_DOWN, 32'h0000_0001);
        rd(`CMP_OFS_CROSS, 32'h0000_0001);
        wr(`CMP_OFS_SAMPLE, 32'h0000_0001);
        rd(`CMP_OFS_RESULT, 32'h0000_0000);
        cmp_out_i <= 1'b1;
        wait_sync();
        wr(`CMP_OFS_SAMPLE, 32'h0000_0001);
        rd(`CMP_OFS_RESULT, 32'h0000_0001);
        wr(`CMP_OFS_MASK_SET, 32'h0000_0009);
        settle();
        chk(irq_o, 32'h0000_0001);
        rd(`CMP_OFS_MASK, 32'h0000_0009);
        wr(`CMP_OFS_MASK_CLR, 32'h0000_0009);
        settle();
        chk(irq_o, 32'h0000_0000);
        wr(`CMP_OFS_MASK, 32'h0000_0002);
        rd(`CMP_OFS_MASK_SET, 32'h0000_0002);
        settle();
        chk(irq_o, 32'h0000_0001);
        foreach (flag_ofs[i]) wr(flag_ofs[i], 32'h0000_0000);
        settle();
        chk(irq_o, 32'h0000_0000);
        wr(`CMP_OFS_STOP, 32'h0000_0001);
        settle();
        chk(core_on_o, 32'h0000_0000);
        cmp_out_i <= 1'b0;
        wait_sync();
        rd(`CMP_OFS_CROSS, 32'h0000_0000);
        wr(`CMP_OFS_LINKS, 32'h0000_0002);
        wr(`CMP_OFS_START, 32'h0000_0001);
        repeat (8) @(posedge clk_i);
        rd(`CMP_OFS_READY, 32'h0000_0001);
        chk(core_on_o, 32'h0000_0000);
        wr(`CMP_OFS_LINKS, 32'h0000_0008);
        wr(`CMP_OFS_START, 32'h0000_0001);
        repeat (8) @(posedge clk_i);
        cmp_out_i <= 1'b1;
        wait_sync();
        chk(core_on_o, 32'h0000_0000);
        rd(`CMP_OFS_UP, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            wr(`CMP_OFS_PIN, {29'h0, v[2:0]});
            wr(`CMP_OFS_REF, {29'h0, v[5:3]});
            wr(`CMP_OFS_EXTREF, {29'h0, v[8:6]});
            settle();
            chk(pin_pick_o, {29'h0, v[2:0]});
            chk(ext_pick_o, {29'h0, v[8:6]});
            chk(ref_pick_o, {29'h0, v[5:3]});
            th = {18'h0, v[21:16], 2'b00, v[29:24]};
            wr(`CMP_OFS_TH, th);
            rd(`CMP_OFS_TH, th);
            settle();
            chk(ladder_o, {26'h0, th[5:0]});
        end
        cmp_out_i <= 1'b0;
        wait_sync();
        settle();
        chk(ladder_o, {26'h0, th[13:8]});
        wr(`CMP_OFS_HYSTERESIS_ON, 32'h0000_0001);
        rd(`CMP_OFS_HYSTERESIS_ON, 32'h0000_0000);
        settle();
        chk(hysteresis_on_o, 32'h0000_0000);
        wr(`CMP_OFS_MODE, 32'h0000_0102);
        settle();
        chk(diff_o, 32'h0000_0001);
        chk(speed_o, 32'h0000_0002);
        chk(ref_pick_o, 32'h0000_0007);
        wr(`CMP_OFS_HYSTERESIS_ON, 32'h0000_0001);
        rd(`CMP_OFS_HYSTERESIS_ON, 32'h0000_0001);
        settle();
        chk(hysteresis_on_o, 32'h0000_0001);
        rd(`CMP_OFS_STATUS, 32'h0000_000d);
        wr(`CMP_OFS_STAT_CLR, 32'h0000_000f);
        rd(`CMP_OFS_STATUS, 32'h0000_0000);
        wr(12'h7f0, 32'hffff_ffff);
        rd(12'h7f0, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        final_report();
    end

endmodule : tb_cmp_regs
